// ---- design/csrr_pkg.sv ----
package csrr_pkg;

  localparam int unsigned CSRR_DATA_W = 24;
  localparam int unsigned CSRR_NUM_PORTS = 8;
  localparam int unsigned CSRR_DSP_W = 48;
  localparam int unsigned CSRR_RAM_DEPTH = 48;
  localparam int unsigned CSRR_RATIO_INT_W = 3;
  localparam int unsigned CSRR_RATIO_FRAC_W = 21;

  // register indices; byte address is four times the index
  localparam logic [5:0] CSRR_IDX_STATUS = 6'h08;
  localparam logic [5:0] CSRR_IDX_RATIO0 = 6'h0d;
  localparam logic [5:0] CSRR_IDX_RATIO2 = 6'h0e;
  localparam logic [5:0] CSRR_IDX_RUN_CFG = 6'h14;
  localparam logic [5:0] CSRR_IDX_CONTROL = 6'h15;
  localparam logic [5:0] CSRR_IDX_PROC_STATE = 6'h16;

  // status word layout
  localparam int unsigned CSRR_ST_IFACE_BIT = 23;
  localparam int unsigned CSRR_ST_TEND_BIT = 22;
  localparam int unsigned CSRR_ST_RUN_BIT = 20;
  localparam int unsigned CSRR_ST_ANYERR_BIT = 16;
  localparam int unsigned CSRR_ST_CAPERR_BIT = 13;
  localparam int unsigned CSRR_ST_PORT_LO = 5;
  localparam int unsigned CSRR_ST_RESERR_BIT = 3;

  localparam int unsigned CSRR_CFG_RUN_BIT = 0;
  localparam int unsigned CSRR_CTL_ROUTE_BIT = 0;
  localparam int unsigned CSRR_CTL_CLR_FLAGS_BIT = 1;
  localparam int unsigned CSRR_CTL_IRQ_ACK_BIT = 2;
  localparam int unsigned CSRR_PST_RUN_BIT = 0;
  localparam int unsigned CSRR_PST_IRQ_BIT = 1;

  localparam logic CSRR_RUN_CFG_RESET = 1'b0;
  localparam logic CSRR_ROUTE_RESET = 1'b0;
  localparam logic [23:0] CSRR_RATIO_RESET = 24'h000000;

  typedef struct packed {
    logic meas_active;
    logic run_done;
    logic cap_conversion_error;
    logic [CSRR_NUM_PORTS-1:0] cap_port_err;
    logic res_err;
  } csrr_fe_t;

  typedef struct packed {
    logic valid;
    logic sel;
    logic [CSRR_DSP_W-1:0] data;
  } csrr_res_wr_t;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [CSRR_DSP_W-1:0] wdata;
  } csrr_ram_req_t;

  typedef enum logic {CSRR_PROC_SLEEP, CSRR_PROC_RUN} csrr_proc_state_t;

endpackage : csrr_pkg

// ---- design/csrr_readout.sv ----
// Summary of operation
// - status bit 23 set on bus traffic during a running measurement
// - status bit 22 set when a resistance measurement run finishes
// - status bit 20 mirrors the run enable configuration bit
// - status bit 16 is the OR of all error conditions
// - status bit 13 set on capacitance converter overflow or error
// - status bits 12 to 5 flag a fault per capacitance port
// - status bit 3 set on resistance converter overflow or error
// - status word at index 8, fixed hardware layout, firmware independent
// - status content independent of processor running or sleeping
// - both ratios are unsigned 3.21 fixed point, 24 bits
// - index 13 returns first sensor to reference ratio
// - index 14 returns second sensor to reference ratio
// - processor works on 48-bit data with a 48 by 48 RAM
// - firmware instruction gates processor clock off until a wake
// - stopped processor wakes on general input or run completion
// - data ready drives active-low interrupt, or active-high pin two when routed
// - configuration register 20 bit 0 is the run enable
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module csrr_readout
  import csrr_pkg::*;
#(
  parameter int unsigned NUM_PORTS = CSRR_NUM_PORTS,
  parameter int unsigned DSP_W = CSRR_DSP_W,
  parameter int unsigned RAM_DEPTH = CSRR_RAM_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csrr_fe_t fe_pins,
  input wire logic gpio_wake_pin,
  input wire logic proc_sleep_req,
  input wire csrr_res_wr_t res_wr,
  input wire logic proc_data_ready,
  input wire csrr_ram_req_t ram_req,
  output logic [DSP_W-1:0] ram_rdata,
  output logic proc_clk_en,
  output logic irq_out_n,
  output logic gpio_two_out,
  output logic gpio_two_oe,
  output logic run_enable
);

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [5:0] idx);
    reg_hit = (a == {idx, 2'b00});
  endfunction : reg_hit

  // pin-side inputs, two flops before any use
  csrr_fe_t fe_meta_reg;
  csrr_fe_t fe_sync_reg;
  logic wake_meta_reg;
  logic wake_sync_reg;
  logic wake_prev_reg;
  logic done_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_meta_reg <= '0;
      fe_sync_reg <= '0;
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
      done_prev_reg <= 1'b0;
    end else if (ce) begin
      fe_meta_reg <= fe_pins;
      fe_sync_reg <= fe_meta_reg;
      wake_meta_reg <= gpio_wake_pin;
      wake_sync_reg <= wake_meta_reg;
      wake_prev_reg <= wake_sync_reg;
      done_prev_reg <= fe_sync_reg.run_done;
    end
  end

  logic wake_rise;
  logic run_done_rise;
  assign wake_rise = wake_sync_reg & ~wake_prev_reg;
  assign run_done_rise = fe_sync_reg.run_done & ~done_prev_reg;

  // apb handshake: data is captured before pready, so a low ce in the
  // setup cycle only adds wait states instead of returning stale data
  logic cap_valid_reg;
  logic apb_done;
  logic wr_done;
  assign pready = penable & cap_valid_reg & ce;
  assign apb_done = psel & penable & pready;
  assign wr_done = apb_done & pwrite;

  logic run_cfg_reg;
  logic route_reg;
  logic clr_flags;
  logic irq_ack;

  assign clr_flags = wr_done & reg_hit(paddr, CSRR_IDX_CONTROL)
                     & pwdata[CSRR_CTL_CLR_FLAGS_BIT];
  assign irq_ack = wr_done & reg_hit(paddr, CSRR_IDX_CONTROL)
                   & pwdata[CSRR_CTL_IRQ_ACK_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cfg_reg <= CSRR_RUN_CFG_RESET;
    end else if (ce && wr_done && reg_hit(paddr, CSRR_IDX_RUN_CFG)) begin
      run_cfg_reg <= pwdata[CSRR_CFG_RUN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_reg <= CSRR_ROUTE_RESET;
    end else if (ce && wr_done && reg_hit(paddr, CSRR_IDX_CONTROL)) begin
      route_reg <= pwdata[CSRR_CTL_ROUTE_BIT];
    end
  end

  assign run_enable = run_cfg_reg;

  // sticky status flags; a set in the clearing cycle wins
  logic iface_flag_reg;
  logic tend_flag_reg;
  logic cap_conversion_error_reg;
  logic res_err_reg;
  logic [NUM_PORTS-1:0] port_err_reg;
  logic iface_set;
  assign iface_set = psel & ~penable & fe_sync_reg.meas_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iface_flag_reg <= 1'b0;
    end else if (ce) begin
      iface_flag_reg <= iface_set | (iface_flag_reg & ~clr_flags);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tend_flag_reg <= 1'b0;
    end else if (ce) begin
      tend_flag_reg <= run_done_rise | (tend_flag_reg & ~clr_flags);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_conversion_error_reg <= 1'b0;
      res_err_reg <= 1'b0;
    end else if (ce) begin
      cap_conversion_error_reg <= fe_sync_reg.cap_conversion_error | (cap_conversion_error_reg & ~clr_flags);
      res_err_reg <= fe_sync_reg.res_err | (res_err_reg & ~clr_flags);
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port_err
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_err_reg[gp] <= 1'b0;
        end else if (ce) begin
          port_err_reg[gp] <= fe_sync_reg.cap_port_err[gp]
                              | (port_err_reg[gp] & ~clr_flags);
        end
      end
    end
  endgenerate

  // built only from converter flags, bus traffic (bit 23) and config, never processor state
  logic [CSRR_DATA_W-1:0] status_word;
  always_comb begin
    status_word = '0; // unassigned bits read zero
    status_word[CSRR_ST_IFACE_BIT] = iface_flag_reg;
    status_word[CSRR_ST_TEND_BIT] = tend_flag_reg;
    status_word[CSRR_ST_RUN_BIT] = run_cfg_reg;
    status_word[CSRR_ST_ANYERR_BIT] = cap_conversion_error_reg | res_err_reg
                                      | (|port_err_reg);
    status_word[CSRR_ST_CAPERR_BIT] = cap_conversion_error_reg;
    status_word[CSRR_ST_PORT_LO +: NUM_PORTS] = port_err_reg;
    status_word[CSRR_ST_RESERR_BIT] = res_err_reg;
  end

  // embedded processor clock gate
  csrr_proc_state_t proc_state_reg;
  logic proc_run;
  assign proc_run = (proc_state_reg == CSRR_PROC_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_state_reg <= CSRR_PROC_RUN;
    end else if (ce) begin
      unique case (proc_state_reg)
        CSRR_PROC_RUN: begin
          if (proc_sleep_req) begin
            proc_state_reg <= CSRR_PROC_SLEEP;
          end
        end
        CSRR_PROC_SLEEP: begin
          if (wake_rise || run_done_rise) begin
            proc_state_reg <= CSRR_PROC_RUN;
          end
        end
      endcase
    end
  end

  assign proc_clk_en = proc_run;

  // results written only by the running processor
  logic [CSRR_DATA_W-1:0] ratio_reg [2];
  genvar gr;
  generate
    for (gr = 0; gr < 2; gr++) begin : g_ratio
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ratio_reg[gr] <= CSRR_RATIO_RESET;
        end else if (ce && proc_run && res_wr.valid
                     && (res_wr.sel == 1'(gr))) begin
          // low 24 bits of the 48-bit word: 3.21 unsigned
          ratio_reg[gr] <= res_wr.data[CSRR_DATA_W-1:0];
        end
      end
    end
  endgenerate

  // working ram, no reset needed on data
  logic [DSP_W-1:0] ram_mem [RAM_DEPTH];
  logic ram_addr_ok;
  assign ram_addr_ok = (32'(ram_req.addr) < RAM_DEPTH);

  always_ff @(posedge pclk) begin
    if (ce && proc_run && ram_req.we && ram_addr_ok) begin
      ram_mem[ram_req.addr] <= ram_req.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_rdata <= '0;
    end else if (ce && proc_run) begin
      ram_rdata <= ram_addr_ok ? ram_mem[ram_req.addr] : '0;
    end
  end

  // data ready interrupt; held until software acknowledges it
  logic irq_pend_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_reg <= 1'b0;
    end else if (ce) begin
      irq_pend_reg <= (proc_run & proc_data_ready)
                      | (irq_pend_reg & ~irq_ack);
    end
  end

  // one flop behind pending so the pins never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_n <= 1'b1;
      gpio_two_out <= 1'b0;
      gpio_two_oe <= 1'b0;
    end else if (ce) begin
      irq_out_n <= ~(irq_pend_reg & ~route_reg);
      gpio_two_out <= irq_pend_reg & route_reg;
      gpio_two_oe <= route_reg;
    end
  end

  // read mux and error decode; reads modify nothing but status bit 23, set during a measurement
  logic [31:0] rd_data;
  logic rd_err;
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (reg_hit(paddr, CSRR_IDX_STATUS)) begin
      rd_data[CSRR_DATA_W-1:0] = status_word;
      rd_err = pwrite;
    end else if (reg_hit(paddr, CSRR_IDX_RATIO0)) begin
      rd_data[CSRR_DATA_W-1:0] = ratio_reg[0];
      rd_err = pwrite;
    end else if (reg_hit(paddr, CSRR_IDX_RATIO2)) begin
      rd_data[CSRR_DATA_W-1:0] = ratio_reg[1];
      rd_err = pwrite;
    end else if (reg_hit(paddr, CSRR_IDX_RUN_CFG)) begin
      rd_data[CSRR_CFG_RUN_BIT] = run_cfg_reg;
    end else if (reg_hit(paddr, CSRR_IDX_CONTROL)) begin
      rd_data[CSRR_CTL_ROUTE_BIT] = route_reg;
    end else if (reg_hit(paddr, CSRR_IDX_PROC_STATE)) begin
      rd_data[CSRR_PST_RUN_BIT] = proc_run;
      rd_data[CSRR_PST_IRQ_BIT] = irq_pend_reg;
      rd_err = pwrite;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_valid_reg <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      cap_valid_reg <= psel & ~(penable & cap_valid_reg);
      if (psel && !cap_valid_reg) begin
        prdata <= pwrite ? 32'h00000000 : rd_data;
        pslverr <= rd_err;
      end
    end
  end

endmodule : csrr_readout

// ---- tb/csrr_readout_chk.sv ----
`timescale 1ns/10ps
module csrr_readout_chk
  import csrr_pkg::*;
#(
  parameter int unsigned DSP_W = CSRR_DSP_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic proc_sleep_req,
  input wire logic proc_data_ready,
  input wire logic [DSP_W-1:0] ram_rdata,
  input wire logic proc_clk_en,
  input wire logic irq_out_n,
  input wire logic gpio_two_out,
  input wire logic gpio_two_oe,
  input wire logic run_enable
);
  logic acc;
  logic mapped;
  logic st_rd;
  assign acc = psel & penable & pready;
  assign mapped = paddr inside {8'h20, 8'h34, 8'h38, 8'h50, 8'h54, 8'h58};
  assign st_rd = acc & !pwrite & (paddr == 8'h20);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_cause: assert property (pready |-> penable && ce)
    else $error("pready outside access");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_status_ro: assert property (acc && pwrite && paddr == 8'h20 |-> pslverr)
    else $error("status write accepted");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:24] == 8'h00)
    else $error("upper read bits set");
  a_run_write: assert property (acc && pwrite && paddr == 8'h50 |=>
    run_enable == $past(pwdata[0]))
    else $error("run enable not written");
  a_run_mirror: assert property (st_rd |-> prdata[20] == run_enable)
    else $error("status run bit differs");
  a_err_or: assert property (st_rd |-> prdata[16] == |{prdata[13:5], prdata[3]})
    else $error("summary error bit wrong");
  a_sleep_gate: assert property (ce && proc_clk_en && proc_sleep_req |=>
    !proc_clk_en)
    else $error("clock not gated");
  a_sleep_frozen: assert property (!proc_clk_en |=> $stable(ram_rdata))
    else $error("ram moved while asleep");
  a_irq_rise: assert property (proc_data_ready && proc_clk_en |->
    ##2 (!irq_out_n || gpio_two_oe))
    else $error("interrupt not raised");
  a_irq_route: assert property (!irq_out_n |-> !gpio_two_out)
    else $error("interrupt on both outputs");
  c_refused: cover property (acc && pslverr);
  c_irq: cover property (!irq_out_n);
  c_wake: cover property (!proc_clk_en ##1 proc_clk_en);
endmodule : csrr_readout_chk

bind csrr_readout csrr_readout_chk #(.DSP_W(DSP_W)) u_chk (.pclk, .presetn,
  .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .proc_sleep_req, .proc_data_ready, .ram_rdata, .proc_clk_en, .irq_out_n,
  .gpio_two_out, .gpio_two_oe, .run_enable);

// ---- tb/csrr_apb_host.sv ----
`timescale 1ns/10ps
module csrr_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // pready is sampled at the rising edge that closes the access phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // released data shows the inverse, never a stale copy
    pwdata <= ~d;
  endtask : xfer
endmodule : csrr_apb_host

// ---- tb/csrr_readout_tb.sv ----
`timescale 1ns/10ps
module csrr_readout_tb;
  import csrr_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic wake, slp, pdr, clk_en, irq_n, g2o, g2e, run_en, run_e;
  logic [7:0] paddr, p8;
  logic [31:0] pwdata, prdata, rd, e;
  logic [47:0] ram_rd;
  logic [23:0] v, r0;
  csrr_fe_t fe;
  csrr_res_wr_t rw;
  csrr_ram_req_t rq;
  integer seed = 62856;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  csrr_readout dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fe_pins(fe),
    .gpio_wake_pin(wake), .proc_sleep_req(slp), .res_wr(rw),
    .proc_data_ready(pdr), .ram_req(rq), .ram_rdata(ram_rd),
    .proc_clk_en(clk_en), .irq_out_n(irq_n), .gpio_two_out(g2o),
    .gpio_two_oe(g2e), .run_enable(run_en));
  csrr_apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task rdr(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rdr
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  function logic [31:0] st_exp(logic [7:0] p, logic c, logic r, logic run);
    return {11'h0, run, 3'h0, c | r | (|p), 2'h0, c, p, 1'b0, r, 3'h0};
  endfunction : st_exp
  task stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    {presetn, wake, slp, pdr} = 4'h0;
    ce = 1;
    fe = '0;
    rw = '0;
    rq = '0;
    tick(8);
    presetn <= 1;
    tick(1);
    chk("irq_n", irq_n, 1);
    chk("clk_en", clk_en, 1);
    rdr(8'h34);
    chk("ratio0", rd, 0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      v = 24'($random(seed));
      run_e = v[0];
      wr(8'h50, {8'h0, v});
      rdr(8'h20);
      chk("status", rd, st_exp(8'h0, 0, 0, run_e));
      chk("st run", rd[20], run_e);
    end
    wr(8'h20, 32'h1);
    chk("ro err", err, 1);
    rdr({2'b11, v[5:0]});
    chk("bad addr", {rd[30:0], err}, 1);
    for (int i = 0; i < 4; i++) begin
      v = 24'($random(seed));
      if (!i[0]) r0 = v;
      rw <= '{valid: 1'b1, sel: i[0], data: {~v, v}};
      tick(1);
      rw <= '0;
      rdr(i[0] ? 8'h38 : 8'h34);
      chk("ratio", rd, {8'h0, v});
      rdr(i[0] ? 8'h38 : 8'h34);
      chk("ratio poll", rd, {8'h0, v});
    end
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      p8 = (i == 2) ? (v[7:0] | 8'h01) : 8'h00;
      fe <= '{meas_active: i == 4, run_done: i == 0, cap_conversion_error: i == 1,
              cap_port_err: p8, res_err: i == 3};
      tick(4);
      if (i == 4) rdr(8'h58);
      fe <= '0;
      tick(4);
      e = st_exp(p8, i == 1, i == 3, run_e) | {8'h0, i == 4, i == 0, 22'h0};
      rdr(8'h20);
      chk("flags", rd, e);
      rdr(8'h20);
      chk("reread", rd, e);
      wr(8'h54, 32'h2);
    end
    $display("status test done");
    for (int i = 0; i < 2; i++) begin
      slp <= 1;
      tick(1);
      slp <= 0;
      chk("asleep", clk_en, 0);
      rw <= '{valid: 1'b1, sel: 1'b0, data: 48'h0};
      tick(1);
      rw <= '0;
      rdr(8'h34);
      chk("frozen", rd, {8'h0, r0});
      rdr(8'h20);
      chk("sleep st", rd, st_exp(8'h0, 0, 0, run_e));
      if (i == 0) wake <= 1;
      else fe.run_done <= 1;
      tick(5);
      {wake, fe} <= '0;
      chk("woken", clk_en, 1);
    end
    wr(8'h54, 32'h2);
    rq <= '{we: 1'b1, addr: 6'd47, wdata: {v, ~v}};
    tick(1);
    rq.we <= 0;
    tick(1);
    chk("ram", ram_rd[31:0], {v[7:0], ~v});
    for (int i = 0; i < 2; i++) begin
      wr(8'h54, i);
      pdr <= 1;
      tick(1);
      pdr <= 0;
      tick(1);
      chk("irq", {irq_n, g2o, g2e}, i ? 3'b111 : 3'b000);
      wr(8'h54, 32'h4 | i);
      tick(2);
      chk("ack", {irq_n, g2o}, 2'b10);
    end
    $display("processor test done");
    stop_test();
  end
endmodule : csrr_readout_tb
